// file: rtl/abm_pkg.sv
/*
 * Types shared by the serial baud, mute and parity block.
 * Assumes nothing of its surroundings.
 */
package abm_pkg;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} abm_rx_state_t;
endpackage

// file: rtl/abm_rate_gen.sv
/*
 * Oversampling tick generator, one per direction.
 * Assumes settings stay fixed while the directions are enabled.
 */
`timescale 1ns/100ps
`include "abm_regs.svh"
module abm_rate_gen
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Settings and ticks
	abm_rate_if.gen rif
);
	logic [3:0] coarse;

	assign coarse = (rif.coarse_sel == 2'h0) ? `ABM_COARSE_F0 :
		(rif.coarse_sel == 2'h1) ? `ABM_COARSE_F1 :
		(rif.coarse_sel == 2'h2) ? `ABM_COARSE_F2 : `ABM_COARSE_F3;

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_dir
			logic [10:0] base;
			logic [7:0] fine_eff;
			logic [18:0] period;
			logic [18:0] cnt;
			logic [18:0] gap;
			logic [18:0] last_period;
			logic moved;
			logic seen;
			assign base = 11'({7'h00, coarse} << rif.div_sel[g]);
			assign fine_eff = (rif.fine[g] == 8'h00) ? 8'h01 : rif.fine[g];
			assign period = 19'(base * fine_eff);
			// tick at sixteen times bit rate
			assign rif.tick[g] = !rif.freeze && (cnt >= period - `ABM_PERIOD_ONE);
			// Settings moved since last cycle
			assign moved = (period != last_period);

			always_ff @(posedge ref_clk)
			begin
				if (reset)
					cnt <= 19'h00000;
				else if (rif.tick[g])
					cnt <= 19'h00000;
				else if (!rif.freeze)
					cnt <= cnt + `ABM_PERIOD_ONE;
			end

			always_ff @(posedge ref_clk)
			begin
				if (reset)
				begin
					gap <= 19'h00000;
					seen <= 1'b0;
				end
				else if (moved)
				begin
					gap <= 19'h00000;
					seen <= 1'b0;
				end
				else if (rif.tick[g])
				begin
					gap <= 19'h00000;
					seen <= 1'b1;
				end
				else if (!rif.freeze)
					gap <= gap + `ABM_PERIOD_ONE;
			end

			always_ff @(posedge ref_clk)
			begin
				if (reset)
					last_period <= `ABM_PERIOD_ONE;
				else
					last_period <= period;
			end

			property p_period;
				@(posedge ref_clk) disable iff (reset)
				(rif.tick[g] && seen && !moved) |-> (gap == period - `ABM_PERIOD_ONE);
			endproperty
			a_period: assert property (p_period) else $error("tick spacing wrong");

			property p_bypass;
				@(posedge ref_clk) disable iff (reset)
				(rif.fine[g] == 8'h00 && rif.coarse_sel == 2'h0 && rif.div_sel[g] == 3'h0
					&& !rif.freeze) |-> rif.tick[g];
			endproperty
			a_bypass: assert property (p_bypass) else $error("bypass rate wrong");

			property p_freeze;
				@(posedge ref_clk) disable iff (reset)
				rif.freeze |=> ($stable(cnt) && !rif.tick[g]) or !rif.freeze;
			endproperty
			a_freeze: assert property (p_freeze) else $error("counter moved in halt");
		end
	endgenerate
endmodule

// file: rtl/abm_rate_if.sv
/*
 * Carrier between the top and the rate generator: settings in, ticks out.
 * Assumes one clock; index 0 is transmit, index 1 is receive.
 */
`timescale 1ns/100ps
interface abm_rate_if;
	logic [1:0] coarse_sel;
	logic [1:0][2:0] div_sel;
	logic [1:0][7:0] fine;
	logic freeze;
	logic [1:0] tick;
	modport gen (input coarse_sel, input div_sel, input fine, input freeze, output tick);
	modport user (output coarse_sel, output div_sel, output fine, output freeze, input tick);
endinterface

// file: rtl/abm_regs.svh
/*
 * Constants of the serial baud, mute and parity block: divider factors,
 * oversampling points, frame lengths and reset values.
 * Assumes inclusion by bare name from the block's design files only.
 */
// What this block does
// - Received break stored as zero, framing error
// - Each direction: clock over sixteen, prescale, divider
// - Coarse prescale one, three, four, thirteen
// - Transmit divider power of two, 1-128
// - Receive divider power of two, independent
// - Fine factor 1-255 divides each direction
// - Fine factor zero bypasses extended prescaler
// - Muted receiver sets no flags, no interrupts
// - Wake on idle or address mark per selector
// - Idle wake clears mute, no idle flag
// - Address mark clears mute, delivers word
// - Parity replaces top data bit in frame
// - Parity even or odd over low bits
// - Transmit sends parity instead of top bit
// - Receive parity mismatch sets flag, interrupt
// - Address mark uses top data bit, not parity
// - Halt freezes transfer and state; wait none
// - Start low, data LSB first, stop high
// - Parity selection changes after current byte
// - Missing stop bit flags framing error
`ifndef ABM_REGS_SVH
`define ABM_REGS_SVH

// ****************************************
// Rate generation
// ****************************************
`define ABM_COARSE_F0 4'h1
`define ABM_COARSE_F1 4'h3
`define ABM_COARSE_F2 4'h4
`define ABM_COARSE_F3 4'hD
`define ABM_PERIOD_ONE 19'h00001

// ****************************************
// Oversampling and framing
// ****************************************
`define ABM_OS_LAST 4'hF
`define ABM_OS_MID 4'h7
`define ABM_FRAME_BITS_8 4'hA
`define ABM_FRAME_BITS_9 4'hB
`define ABM_DATA_LAST_8 4'h7
`define ABM_DATA_LAST_9 4'h8
`define ABM_IDLE_TICKS_8 8'hA0
`define ABM_IDLE_TICKS_9 8'hB0
`define ABM_PAR_MASK_8 8'h7F
`define ABM_PAR_MASK_9 8'hFF
`define ABM_TX_LINE_IDLE 11'h7FF
`define ABM_BREAK_VALUE 9'h000
`define ABM_RX_DATA_RESET 9'h000

`endif

// file: rtl/abm_serial_top.sv
/*
 * Serial transmitter and receiver with independent rates, muting with
 * wake-up, byte parity, break detection and halt freeze.
 * Assumes configuration ports come from logic on ref_clk; rx_pin is
 * asynchronous; settings are held while the directions are enabled.
 */
`timescale 1ns/100ps
`include "abm_regs.svh"
module abm_serial_top
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Rate settings
	input wire logic [1:0] coarse_prescale_sel,
	input wire logic [2:0] tx_rate_divider_sel,
	input wire logic [2:0] rx_rate_divider_sel,
	input wire logic [7:0] tx_fine_prescale_register,
	input wire logic [7:0] rx_fine_prescale_register,
	// Frame control
	input wire logic word_9bit,
	input wire logic parity_enable,
	input wire logic parity_odd_sel,
	input wire logic parity_int_en,
	input wire logic wake_addr_sel,
	input wire logic tx_enable,
	input wire logic rx_enable,
	input wire logic halt_mode,
	// Muting
	input wire logic mute_set,
	output logic mute_request,
	// Transmit side
	input wire logic [8:0] tx_data,
	input wire logic tx_write,
	output logic tx_ready,
	output logic tx_pin,
	// Receive side
	input wire logic rx_pin,
	input wire logic rx_read,
	output logic [8:0] serial_data_buffer,
	output logic rx_full_flag,
	output logic framing_error_flag,
	output logic parity_error_flag,
	output logic idle_flag,
	output logic parity_irq
);
	// ****************************************
	// Rate generation
	// ****************************************
	abm_rate_if rif ();
	logic run;

	assign run = !halt_mode;
	assign rif.coarse_sel = coarse_prescale_sel;
	assign rif.div_sel[0] = tx_rate_divider_sel;
	assign rif.div_sel[1] = rx_rate_divider_sel;
	assign rif.fine[0] = tx_fine_prescale_register;
	assign rif.fine[1] = rx_fine_prescale_register;
	assign rif.freeze = halt_mode;

	abm_rate_gen u_rate
	(
		.ref_clk(ref_clk),
		.reset(reset),
		.rif(rif)
	);

	// ****************************************
	// Transmitter
	// ****************************************
	logic [3:0] tx_os;
	logic [3:0] tx_bits;
	logic [10:0] tx_shift;
	logic tx_bit_tick;
	logic tx_load;
	logic tx_par;
	logic [7:0] tx_mask;
	logic [8:0] tx_word;

	assign tx_mask = word_9bit ? `ABM_PAR_MASK_9 : `ABM_PAR_MASK_8;
	assign tx_par = (^(tx_data[7:0] & tx_mask)) ^ parity_odd_sel;
	// parity in place of top bit
	assign tx_word = word_9bit ? {(parity_enable ? tx_par : tx_data[8]), tx_data[7:0]} :
		{1'b1, (parity_enable ? tx_par : tx_data[7]), tx_data[6:0]};
	assign tx_ready = tx_enable && run && (tx_bits == 4'h0);
	assign tx_load = tx_write && tx_ready;
	assign tx_bit_tick = rif.tick[0] && (tx_os == `ABM_OS_LAST);
	assign tx_pin = tx_shift[0];

	always_ff @(posedge ref_clk)
	begin
		if (reset)
			tx_os <= 4'h0;
		else if (tx_load)
			tx_os <= 4'h0;
		else if (rif.tick[0])
			tx_os <= tx_os + 4'h1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			tx_shift <= `ABM_TX_LINE_IDLE;
			tx_bits <= 4'h0;
		end
		else if (tx_load)
		begin
			tx_shift <= {1'b1, tx_word, 1'b0};
			tx_bits <= word_9bit ? `ABM_FRAME_BITS_9 : `ABM_FRAME_BITS_8;
		end
		else if (tx_bit_tick && tx_bits != 4'h0)
		begin
			tx_shift <= {1'b1, tx_shift[10:1]};
			tx_bits <= tx_bits - 4'h1;
		end
	end

	// ****************************************
	// Receive line and sampling
	// ****************************************
	abm_pkg::abm_rx_state_t rx_state;
	abm_pkg::abm_rx_state_t next_rx_state;
	logic rx_meta;
	logic rx_line;
	logic [3:0] rx_os;
	logic [3:0] rx_cnt;
	logic [8:0] rx_shift;
	logic rx_odd;
	logic rx_tick;
	logic rx_mid;
	logic rx_done;
	logic [3:0] rx_last;

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			rx_meta <= 1'b1;
			rx_line <= 1'b1;
		end
		else
		begin
			rx_meta <= rx_pin;
			rx_line <= rx_meta;
		end
	end

	assign rx_tick = rif.tick[1] && rx_enable;
	assign rx_mid = rx_tick && (rx_os == `ABM_OS_LAST);
	assign rx_last = word_9bit ? `ABM_DATA_LAST_9 : `ABM_DATA_LAST_8;
	assign rx_done = (rx_state == abm_pkg::RX_STOP) && rx_mid;

	always_comb
	begin
		next_rx_state = rx_state;
		case (rx_state)
			abm_pkg::RX_IDLE:
				if (rx_tick && !rx_line)
					next_rx_state = abm_pkg::RX_START;
			abm_pkg::RX_START:
				if (rx_tick && rx_os == `ABM_OS_MID)
					next_rx_state = rx_line ? abm_pkg::RX_IDLE : abm_pkg::RX_DATA;
			abm_pkg::RX_DATA:
				if (rx_mid && rx_cnt == rx_last)
					next_rx_state = abm_pkg::RX_STOP;
			abm_pkg::RX_STOP:
				if (rx_mid)
					next_rx_state = abm_pkg::RX_IDLE;
			default:
				next_rx_state = abm_pkg::RX_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset || !rx_enable)
			rx_state <= abm_pkg::RX_IDLE;
		else
			rx_state <= next_rx_state;
	end

	// Start found at mid bit, then one sample per bit centre
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			rx_os <= 4'h0;
		else if (rx_state != next_rx_state && next_rx_state != abm_pkg::RX_STOP)
			rx_os <= 4'h0;
		else if (rx_tick)
			rx_os <= rx_os + 4'h1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			rx_cnt <= 4'h0;
			rx_shift <= 9'h000;
			rx_odd <= 1'b0;
		end
		else if (rx_state == abm_pkg::RX_START)
		begin
			rx_cnt <= 4'h0;
			rx_odd <= parity_odd_sel;
		end
		else if (rx_state == abm_pkg::RX_DATA && rx_mid)
		begin
			rx_shift <= {rx_line, rx_shift[8:1]};
			rx_cnt <= rx_cnt + 4'h1;
		end
	end

	// ****************************************
	// Word checks and wake-up
	// ****************************************
	logic [8:0] rx_word;
	logic rx_msb;
	logic rx_par_bad;
	logic rx_brk;
	logic addr_wake;
	logic idle_wake;
	logic deliver;
	logic store;
	logic [7:0] idle_cnt;
	logic [7:0] idle_thresh;
	logic idle_hit;
	logic idle_arm;
	logic idle_set;

	assign rx_word = word_9bit ? rx_shift : {1'b0, rx_shift[8:1]};
	assign rx_msb = word_9bit ? (parity_enable ? rx_word[7] : rx_word[8]) :
		(parity_enable ? rx_word[6] : rx_word[7]);
	assign rx_par_bad = parity_enable && ((^rx_word) != rx_odd);
	// all zero and no stop is a break
	assign rx_brk = !rx_line && (rx_word == `ABM_BREAK_VALUE);
	assign addr_wake = mute_request && wake_addr_sel && rx_done && rx_msb;
	assign deliver = rx_done && (!mute_request || addr_wake);
	assign store = deliver && !rx_full_flag;

	assign idle_thresh = word_9bit ? `ABM_IDLE_TICKS_9 : `ABM_IDLE_TICKS_8;
	assign idle_hit = rx_tick && rx_line && (idle_cnt == idle_thresh - 8'h01);
	assign idle_wake = mute_request && !wake_addr_sel && idle_hit;
	assign idle_set = idle_hit && !mute_request && idle_arm;

	always_ff @(posedge ref_clk)
	begin
		if (reset || !rx_enable)
			idle_cnt <= 8'h00;
		else if (rx_tick && !rx_line)
			idle_cnt <= 8'h00;
		else if (rx_tick && idle_cnt != idle_thresh)
			idle_cnt <= idle_cnt + 8'h01;
	end

	// ****************************************
	// Flags and receive buffer
	// ****************************************
	logic clr;

	assign clr = rx_read && run;

	always_ff @(posedge ref_clk)
	begin
		if (reset)
			mute_request <= 1'b0;
		else if (run)
			mute_request <= mute_set || (mute_request && !(idle_wake || addr_wake));
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
			serial_data_buffer <= `ABM_RX_DATA_RESET;
		else if (store)
			serial_data_buffer <= rx_brk ? `ABM_BREAK_VALUE : rx_word;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			rx_full_flag <= 1'b0;
			framing_error_flag <= 1'b0;
			parity_error_flag <= 1'b0;
			idle_flag <= 1'b0;
			idle_arm <= 1'b0;
		end
		else
		begin
			rx_full_flag <= store || (rx_full_flag && !clr);
			framing_error_flag <= (store && !rx_line) || (framing_error_flag && !clr);
			parity_error_flag <= (store && rx_par_bad) || (parity_error_flag && !clr);
			idle_flag <= idle_set || (idle_flag && !clr);
			idle_arm <= store || (idle_arm && !idle_set);
		end
	end

	assign parity_irq = parity_error_flag && parity_int_en && !mute_request;

	// ****************************************
	// Checks
	// ****************************************
	property p_break_zero;
		@(posedge ref_clk) disable iff (reset)
		(store && rx_brk) |=> (serial_data_buffer == `ABM_BREAK_VALUE) && framing_error_flag;
	endproperty
	a_break_zero: assert property (p_break_zero) else $error("break not zero");

	property p_mute_quiet;
		@(posedge ref_clk) disable iff (reset)
		(mute_request && !idle_wake && !addr_wake) |=>
			!$rose(rx_full_flag) && !$rose(idle_flag) && !$rose(parity_error_flag);
	endproperty
	a_mute_quiet: assert property (p_mute_quiet) else $error("flag set while muted");

	property p_idle_wake;
		@(posedge ref_clk) disable iff (reset)
		(idle_wake && !mute_set && run) |=> !mute_request && !$rose(idle_flag);
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle wake wrong");

	property p_addr_wake;
		@(posedge ref_clk) disable iff (reset)
		(addr_wake && !rx_full_flag && !mute_set && run) |=>
			!mute_request && rx_full_flag && serial_data_buffer == $past(rx_word);
	endproperty
	a_addr_wake: assert property (p_addr_wake) else $error("address wake wrong");

	property p_parity_err;
		@(posedge ref_clk) disable iff (reset)
		(store && rx_par_bad && !mute_set) |=> parity_error_flag && (parity_irq == parity_int_en);
	endproperty
	a_parity_err: assert property (p_parity_err) else $error("parity error missed");

	property p_start_low;
		@(posedge ref_clk) disable iff (reset)
		tx_load |=> !tx_pin ##1 !tx_pin;
	endproperty
	a_start_low: assert property (p_start_low) else $error("start bit not low");

	property p_halt_hold;
		@(posedge ref_clk) disable iff (reset)
		(halt_mode && !reset) |=> $stable(tx_pin) && $stable(serial_data_buffer)
			&& $stable(mute_request);
	endproperty
	a_halt_hold: assert property (p_halt_hold) else $error("state moved in halt");
endmodule

// file: sim/abm_remote_node.sv
/*
 * Remote serial node: sends frames on the block's receive line and
 * decodes frames from the block's transmit line.
 * Assumes one clock shared with the bench; frame shapes set by the bench.
 */
`timescale 1ns/100ps
module abm_remote_node
(
	// Clock
	input wire logic ref_clk,
	// Serial lines
	input wire logic tx_pin,
	output logic rx_pin,
	// Shape of frames from the block
	input int tx_bit,
	input int tx_len,
	// Decoded frame
	output logic [8:0] got_word,
	output logic got_stop,
	output logic got_valid
);
	logic start_ok;

	initial
	begin
		rx_pin = 1'b1;
		got_word = 9'h000;
		got_stop = 1'b0;
		got_valid = 1'b0;
	end

	task automatic send(input logic [8:0] w, input int len, input int bit_c, input logic stop);
		rx_pin = 1'b0;
		repeat (bit_c) @(negedge ref_clk);
		for (int i = 0; i < len; i++)
		begin
			rx_pin = w[i];
			repeat (bit_c) @(negedge ref_clk);
		end
		rx_pin = stop;
		// Low stop cut short, then a high mark
		repeat (stop ? bit_c : bit_c * 3 / 4) @(negedge ref_clk);
		rx_pin = 1'b1;
		if (!stop)
			repeat (bit_c) @(negedge ref_clk);
	endtask

	always
	begin
		@(negedge tx_pin);
		got_word = 9'h000;
		repeat (tx_bit / 2) @(negedge ref_clk);
		start_ok = ~tx_pin;
		for (int i = 0; i < tx_len; i++)
		begin
			repeat (tx_bit) @(negedge ref_clk);
			got_word[i] = tx_pin;
		end
		repeat (tx_bit) @(negedge ref_clk);
		got_stop = tx_pin & start_ok;
		got_valid = 1'b1;
		@(negedge ref_clk);
		got_valid = 1'b0;
	end
endmodule

// file: sim/tb_top.sv
/*
 * Bench of the serial block: both directions, rates, parity, mute, halt.
 * Assumes the remote node model drives the receive line.
 */
`timescale 1ns/100ps
module tb_top;
	logic ref_clk, reset, word_9bit, parity_enable, parity_odd_sel, parity_int_en;
	logic [1:0] coarse_prescale_sel;
	logic [2:0] tx_rate_divider_sel, rx_rate_divider_sel;
	logic [7:0] tx_fine_prescale_register, rx_fine_prescale_register;
	logic wake_addr_sel, tx_enable, rx_enable, halt_mode, mute_set, mute_request;
	logic [8:0] tx_data, serial_data_buffer, got_word;
	logic tx_write, tx_ready, tx_pin, rx_pin, rx_read, got_stop, got_valid;
	logic rx_full_flag, framing_error_flag, parity_error_flag, idle_flag, parity_irq;
	logic [11:0] rx_e, tx_e;
	logic [10:0] rx_q[$];
	logic [9:0] tx_q[$];
	int bad_count, cmp_count, cycles, seed, tx_bit, rx_bit, tx_len;

	abm_serial_top dut (.ref_clk, .reset, .coarse_prescale_sel, .tx_rate_divider_sel,
		.rx_rate_divider_sel, .tx_fine_prescale_register, .rx_fine_prescale_register,
		.word_9bit, .parity_enable, .parity_odd_sel, .parity_int_en, .wake_addr_sel,
		.tx_enable, .rx_enable, .halt_mode, .mute_set, .mute_request, .tx_data, .tx_write,
		.tx_ready, .tx_pin, .rx_pin, .rx_read, .serial_data_buffer, .rx_full_flag,
		.framing_error_flag, .parity_error_flag, .idle_flag, .parity_irq);
	abm_remote_node node (.ref_clk, .tx_pin, .rx_pin, .tx_bit, .tx_len, .got_word,
		.got_stop, .got_valid);

	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// ****************
	// Helpers
	// ****************
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic cfg(input int c, input int td, input int rd, input int tf, input int rf,
		input logic w9, input logic pen, input logic odd);
		int cf[4] = '{1, 3, 4, 13};
		@(negedge ref_clk);
		tx_enable = 1'b0;
		rx_enable = 1'b0;
		@(negedge ref_clk);
		coarse_prescale_sel = 2'(c);
		tx_rate_divider_sel = 3'(td);
		rx_rate_divider_sel = 3'(rd);
		tx_fine_prescale_register = 8'(tf);
		rx_fine_prescale_register = 8'(rf);
		word_9bit = w9;
		parity_enable = pen;
		parity_odd_sel = odd;
		tx_bit = 16 * cf[c] * (1 << td) * (tf == 0 ? 1 : tf);
		rx_bit = 16 * cf[c] * (1 << rd) * (rf == 0 ? 1 : rf);
		tx_len = w9 ? 9 : 8;
		@(negedge ref_clk);
		tx_enable = 1'b1;
		rx_enable = 1'b1;
	endtask

	task automatic tx_word(input logic [8:0] d);
		logic p;
		int n;
		p = (word_9bit ? ^d[7:0] : ^d[6:0]) ^ parity_odd_sel;
		if (!parity_enable)
			tx_q.push_back({1'b1, word_9bit ? d : {1'b0, d[7:0]}});
		else
			tx_q.push_back({1'b1, word_9bit ? {p, d[7:0]} : {1'b0, p, d[6:0]}});
		tx_data = d;
		tx_write = 1'b1;
		@(negedge ref_clk);
		tx_write = 1'b0;
		n = 0;
		while (tx_ready !== 1'b1 && n < 40000)
		begin
			@(negedge ref_clk);
			n++;
		end
	endtask

	task automatic rx_word(input logic [8:0] d, input logic stop);
		logic [8:0] v;
		logic pe;
		v = word_9bit ? d : {1'b0, d[7:0]};
		// parity over data and parity bit
		pe = parity_enable & ((^v) ^ parity_odd_sel);
		rx_q.push_back({~stop, pe, v});
		node.send(v, tx_len, rx_bit, stop);
	endtask

	task automatic pulse_mute();
		@(negedge ref_clk);
		mute_set = 1'b1;
		@(negedge ref_clk);
		mute_set = 1'b0;
	endtask

	// ****************
	// Result watchers
	// ****************
	always @(posedge rx_full_flag)
	begin
		@(negedge ref_clk);
		rx_e = rx_q.size() > 0 ? {1'b0, rx_q.pop_front()} : 12'hFFF;
		check({1'b0, framing_error_flag, parity_error_flag, serial_data_buffer}, rx_e);
		check(parity_irq, rx_e[9] & parity_int_en);
		rx_read = 1'b1;
		@(negedge ref_clk);
		rx_read = 1'b0;
	end

	always @(posedge got_valid)
	begin
		tx_e = tx_q.size() > 0 ? {2'b00, tx_q.pop_front()} : 12'hFFF;
		check({2'b00, got_stop, got_word}, tx_e);
	end

	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 100000)
		begin
			bad_count++;
			complete_run();
		end
	end

	// ****************
	// Main sequence
	// ****************
	initial
	begin
		{bad_count, cmp_count, cycles, seed} = {32'h00000000, 32'h00000000, 32'h00000000, 32'h00000025};
		{reset, tx_enable, rx_enable, halt_mode, mute_set, tx_write, rx_read} = 7'h40;
		{word_9bit, parity_enable, parity_odd_sel, parity_int_en, wake_addr_sel} = 5'h00;
		{coarse_prescale_sel, tx_rate_divider_sel, rx_rate_divider_sel} = 8'h00;
		{tx_fine_prescale_register, rx_fine_prescale_register, tx_data} = 25'h0000000;
		{tx_bit, rx_bit, tx_len} = {32'h00000010, 32'h00000010, 32'h00000008};
		repeat (10) @(negedge ref_clk);
		reset = 1'b0;
		for (int m = 0; m < 6; m++)
		begin
			cfg(0, 0, 0, 0, 0, m[0], m >= 2, m >= 4);
			parity_int_en = 1'($random(seed));
			repeat (3)
				fork
					tx_word(9'($random(seed)));
					rx_word(9'($random(seed)), 1'b1);
				join
		end
		for (int i = 0; i < 4; i++)
		begin
			cfg(i, 3 - i, i, i % 2 * 2, 4 - i, 1'b0, 1'b0, 1'b0);
			fork
				tx_word(9'($random(seed)));
				rx_word(9'($random(seed)), 1'b1);
			join
		end
		cfg(0, 0, 0, 0, 0, 1'b0, 1'b0, 1'b0);
		rx_word(9'h000, 1'b0);
		rx_word(9'h05A, 1'b0);
		cfg(0, 0, 0, 0, 0, 1'b0, 1'b1, 1'b0);
		repeat (3000) @(negedge ref_clk);
		check(idle_flag, 1'b1);
		rx_read = 1'b1;
		@(negedge ref_clk);
		rx_read = 1'b0;
		fork
			node.send(9'h012, 8, 16, 1'b1);
			begin
				repeat (40) @(negedge ref_clk);
				pulse_mute();
			end
		join
		check({rx_full_flag, mute_request}, 2'b01);
		repeat (2700) @(negedge ref_clk);
		check({mute_request, idle_flag}, 2'b00);
		wake_addr_sel = 1'b1;
		pulse_mute();
		node.send(9'h081, 8, 16, 1'b1);
		check({rx_full_flag, mute_request}, 2'b01);
		rx_word(9'h041, 1'b1);
		check(mute_request, 1'b0);
		@(negedge ref_clk);
		halt_mode = 1'b1;
		tx_data = 9'h0FF;
		tx_write = 1'b1;
		mute_set = 1'b1;
		@(negedge ref_clk);
		tx_write = 1'b0;
		mute_set = 1'b0;
		check({tx_ready, mute_request, tx_pin}, 3'b001);
		repeat (200) @(negedge ref_clk);
		check(tx_pin, 1'b1);
		halt_mode = 1'b0;
		repeat (400) @(negedge ref_clk);
		complete_run();
	end
endmodule
